/* swps_top.sv */
`timescale 1ns/1ps
`include "swps_cfg.svh"
module swps_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Avalon-MM slave
   input wire logic [`SWPS_AW-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Central memory storage buffer
   input wire logic [`SWPS_NVP-1:0] MEM_AVAIL,
   input wire logic MEM_RVALID,
   input wire logic [`SWPS_VPW-1:0] MEM_RVP,
   input wire logic [31:0] MEM_RDATA,
   output swps_pkg::swps_mreq_s MEM_REQ,
   // Pipe advance strobe
   output logic PIPE_ADVANCE
);
   import swps_pkg::*;

   // ***************************
   // Storage
   // ***************************
   logic [31:0] greg_q [0:`SWPS_NVP-1][0:`SWPS_NGR-1];
   logic [31:0] cr_q [0:`SWPS_NCR-1];
   swps_ir_s ir_q [0:`SWPS_NVP-1];
   logic [`SWPS_EAW-1:0] pc_q [0:`SWPS_NVP-1];
   logic [31:0] nir_q [0:`SWPS_NVP-1];
   logic [31:0] bdr_q [0:`SWPS_NVP-1];
   swps_ir_s mir_q;
   swps_phase_e phase_q;
   logic [`SWPS_VPW-1:0] vp_q;
   logic [`SWPS_VPW-1:0] sel_q;
   logic run_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   swps_mreq_s mreq_q;
   logic adv_q;
   logic ir_hit_q;

   // ***************************
   // Helpers
   // ***************************
   function automatic logic [2:0] cls_def(input logic [2:0] st);
      // Unlisted stored codes read back as class 2
      unique case (st)
         `SWPS_CLS3_ST: cls_def = `SWPS_CLS3_DEF;
         `SWPS_CLS4_ST: cls_def = `SWPS_CLS4_DEF;
         `SWPS_CLS7_ST: cls_def = `SWPS_CLS7_DEF;
         default: cls_def = `SWPS_CLS2_DEF;
      endcase
   endfunction : cls_def

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      be_merge = r;
   endfunction : be_merge

   // New instruction register contents from an instruction word
   function automatic swps_ir_s decode(input logic [31:0] w);
      swps_ir_s r;
      r = '0;
      r.op = w[`SWPS_W_OP];
      r.src = w[`SWPS_W_SRC];
      r.is_cr = w[`SWPS_W_CR];
      r.flg.rind = w[`SWPS_W_IND]; // RULE7
      r.ea = w[`SWPS_W_EA]; // RULE18
      r.flg.mode = 1'b1; // RULE1
      if (r.op == `SWPS_OP_STORE_WORD)
      begin
         r.cls = `SWPS_CLS4_ST; // RULE12
         r.stp = `SWPS_STEP1_DEF ^ `SWPS_STEP_INV; // RULE11
      end
      else
      begin
         // Other groups are not sequenced here; they park
         r.cls = `SWPS_CLS7_ST;
         r.stp = `SWPS_STEP8_DEF ^ `SWPS_STEP_INV;
      end
      decode = r;
   endfunction : decode

   // ***************************
   // Step sequencing
   // ***************************
   logic go;
   logic st1;
   logic eq;
   logic adv;
   logic [2:0] cdef;
   logic [2:0] sdef;
   logic [31:0] src_word;
   logic [31:0] nxt_word;
   logic [`SWPS_EAW-1:0] ea_inc;
   swps_ir_s ir_d;

   // A stale copy of the served register never steps
   assign go = (phase_q == PH_EXEC) && run_q && MEM_AVAIL[vp_q] && !ir_hit_q; // RULE22
   assign cdef = cls_def(mir_q.cls);
   assign sdef = mir_q.stp ^ `SWPS_STEP_INV; // RULE11
   // Word reaches the aligner bus from either register file
   assign src_word = mir_q.is_cr ? cr_q[mir_q.src] : greg_q[vp_q][mir_q.src[2:0]]; // RULE13 RULE10
   assign nxt_word = mir_q.flg.next_location_flag ? nir_q[vp_q] : bdr_q[vp_q]; // RULE2
   assign ea_inc = mir_q.ea + `SWPS_EAW'(1); // RULE15

   always_comb
   begin
      st1 = 1'b0;
      eq = 1'b0;
      adv = 1'b0;
      if (go)
      begin
         if (cdef == `SWPS_CLS4_DEF && sdef == `SWPS_STEP1_DEF)
            st1 = 1'b1; // RULE12
         else if (cdef == `SWPS_CLS3_DEF && sdef == `SWPS_STEP1_DEF)
         begin
            eq = mir_q.flg.write_cycle_equality; // RULE17
            adv = !mir_q.flg.write_cycle_equality; // RULE18
         end
         else if (cdef == `SWPS_CLS3_DEF && sdef == `SWPS_STEP2_DEF)
            adv = 1'b1; // RULE21
      end
   end

   always_comb
   begin
      ir_d = mir_q;
      ir_d.flg.term = 1'b0;
      ir_d.flg.rc = 1'b0;
      ir_d.flg.wc = 1'b0;
      if (st1)
      begin
         ir_d.flg.next_location_flag = 1'b1; // RULE14
         ir_d.flg.wc = 1'b1; // RULE4 RULE16
         ir_d.eap1 = ea_inc; // RULE15
         ir_d.flg.write_cycle_equality = (ea_inc == pc_q[vp_q]); // RULE5
         ir_d.cls = `SWPS_CLS3_ST; // RULE16
         ir_d.stp = `SWPS_STEP1_DEF ^ `SWPS_STEP_INV;
      end
      else if (eq)
      begin
         ir_d.cls = `SWPS_CLS3_ST; // RULE17
         ir_d.stp = `SWPS_STEP2_DEF ^ `SWPS_STEP_INV;
      end
      else if (adv)
      begin
         ir_d = decode(nxt_word); // RULE18
         ir_d.flg.term = 1'b1; // RULE3
         ir_d.flg.rc = 1'b1; // RULE4 RULE20
         ir_d.flg.next_location_flag = 1'b0; // RULE20
      end
   end

   // ***************************
   // Execution time slots
   // ***************************
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         phase_q <= PH_LOAD;
         vp_q <= '0;
      end
      else if (phase_q == PH_LOAD)
         phase_q <= PH_EXEC;
      else
      begin
         phase_q <= PH_LOAD;
         vp_q <= vp_q + `SWPS_VPW'(1);
      end
   end

   // Served processor's register opens its active period
   always_ff @(posedge CLK)
   begin
      if (RESET)
         mir_q <= '0;
      else if (phase_q == PH_LOAD)
         mir_q <= ir_q[vp_q]; // RULE9
   end

   // ***************************
   // Bus slave handshake
   // ***************************
   logic serve;
   logic bus_wr;
   logic [`SWPS_AW-1:0] a;
   // Register file windows and the merged program counter word
   logic gr_hit;
   logic cr_hit;
   logic [2:0] gr_idx;
   logic [5:0] cr_idx;
   logic [31:0] pc_bus;
   // Served only in load phase so the bus never collides with a step write-back
   assign serve = (AVS_READ || AVS_WRITE) && wait_q && (phase_q == PH_LOAD);
   assign bus_wr = serve && AVS_WRITE;
   assign a = {AVS_ADDRESS[`SWPS_AW-1:2], 2'b00};
   assign gr_hit = (a[`SWPS_GR_RGN] == `SWPS_GR_BASE);
   assign cr_hit = (a[`SWPS_CR_RGN] == `SWPS_CR_BASE);
   assign gr_idx = a[`SWPS_GR_IDX];
   assign cr_idx = a[`SWPS_CR_IDX];
   // Only the low half of the merged word reaches the program counter
   assign pc_bus = be_merge({16'h0, pc_q[sel_q]}, AVS_WRITEDATA, AVS_BYTEENABLE);

   always_ff @(posedge CLK)
   begin
      if (RESET)
         wait_q <= 1'b1;
      else
         wait_q <= !serve;
   end

   // A bus write to the served instruction register leaves the copy just taken stale;
   // that slot's step is dropped so its write-back cannot undo the bus write
   always_ff @(posedge CLK)
   begin
      if (RESET)
         ir_hit_q <= 1'b0;
      else
         ir_hit_q <= bus_wr && (a == `SWPS_A_IRW || a == `SWPS_A_FLAGS) && sel_q == vp_q;
   end

   always_comb
   begin
      rdata_d = 32'h0;
      // Register windows first, then the single registers
      if (gr_hit)
         rdata_d = greg_q[sel_q][gr_idx];
      else if (cr_hit)
         rdata_d = cr_q[cr_idx];
      else
         unique case (a)
            `SWPS_A_CTRL: rdata_d = {31'h0, run_q};
            `SWPS_A_STATUS: rdata_d = {27'h0, phase_q == PH_EXEC, run_q, vp_q};
            `SWPS_A_VPSEL: rdata_d = {29'h0, sel_q};
            `SWPS_A_PC: rdata_d = {16'h0, pc_q[sel_q]};
            `SWPS_A_IRW: rdata_d = {ir_q[sel_q].op, ir_q[sel_q].src, ir_q[sel_q].is_cr,
                                    ir_q[sel_q].flg.rind, ir_q[sel_q].ea};
            `SWPS_A_FLAGS: rdata_d = {13'h0, ir_q[sel_q].stp, 1'b0, ir_q[sel_q].cls,
                                      2'h0, ir_q[sel_q].flg};
            `SWPS_A_NIR: rdata_d = nir_q[sel_q];
            `SWPS_A_BDR: rdata_d = bdr_q[sel_q];
            default: rdata_d = 32'h0;
         endcase
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
         rdata_q <= 32'h0;
      else if (serve && AVS_READ)
         rdata_q <= rdata_d;
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         run_q <= 1'b0;
         sel_q <= '0;
      end
      else if (bus_wr && a == `SWPS_A_CTRL && AVS_BYTEENABLE[0])
         run_q <= AVS_WRITEDATA[`SWPS_F_RUN];
      else if (bus_wr && a == `SWPS_A_VPSEL && AVS_BYTEENABLE[0])
         sel_q <= AVS_WRITEDATA[`SWPS_VPW-1:0];
   end

   // ***************************
   // Register files
   // ***************************
   always_ff @(posedge CLK)
   begin
      if (RESET)
         for (int i = 0; i < `SWPS_NCR; i++)
            cr_q[i] <= 32'h0;
      else if (bus_wr && cr_hit)
         cr_q[cr_idx] <= be_merge(cr_q[cr_idx], AVS_WRITEDATA, AVS_BYTEENABLE);
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         for (int v = 0; v < `SWPS_NVP; v++)
            for (int g = 0; g < `SWPS_NGR; g++)
               greg_q[v][g] <= 32'h0;
      end
      else if (bus_wr && gr_hit)
         greg_q[sel_q][gr_idx] <= be_merge(greg_q[sel_q][gr_idx], AVS_WRITEDATA, AVS_BYTEENABLE);
   end

   // Per-processor pipe registers
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         for (int v = 0; v < `SWPS_NVP; v++)
         begin
            ir_q[v] <= '0;
            pc_q[v] <= '0;
            nir_q[v] <= 32'h0;
            bdr_q[v] <= 32'h0;
         end
      end
      else
      begin
         if (MEM_RVALID)
            bdr_q[MEM_RVP] <= MEM_RDATA;
         if (go)
            ir_q[vp_q] <= ir_d; // RULE10
         if (st1)
         begin
            nir_q[vp_q] <= bdr_q[vp_q]; // RULE14
            bdr_q[vp_q] <= src_word; // RULE12 RULE13
         end
         if (eq)
            nir_q[vp_q] <= bdr_q[vp_q]; // RULE17
         if (adv)
            pc_q[vp_q] <= pc_q[vp_q] + `SWPS_EAW'(1); // RULE19
         if (bus_wr)
            unique case (a)
               `SWPS_A_PC: pc_q[sel_q] <= pc_bus[`SWPS_EAW-1:0];
               `SWPS_A_IRW: ir_q[sel_q] <= decode(AVS_WRITEDATA);
               `SWPS_A_FLAGS:
               begin
                  ir_q[sel_q].flg <= AVS_WRITEDATA[`SWPS_F_FLG]; // RULE6 RULE8
                  ir_q[sel_q].cls <= AVS_WRITEDATA[`SWPS_F_CLS];
                  ir_q[sel_q].stp <= AVS_WRITEDATA[`SWPS_F_STP];
               end
               `SWPS_A_NIR: nir_q[sel_q] <= be_merge(nir_q[sel_q], AVS_WRITEDATA, AVS_BYTEENABLE);
               `SWPS_A_BDR: bdr_q[sel_q] <= be_merge(bdr_q[sel_q], AVS_WRITEDATA, AVS_BYTEENABLE);
               default: ;
            endcase
      end
   end

   // ***************************
   // Memory requests
   // ***************************
   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         mreq_q <= '0;
         adv_q <= 1'b0;
      end
      else
      begin
         mreq_q.wr <= st1; // RULE16
         mreq_q.rd <= adv; // RULE20
         mreq_q.vp <= vp_q;
         mreq_q.addr <= st1 ? mir_q.ea : pc_q[vp_q]; // RULE14 RULE19
         mreq_q.wdata <= src_word;
         adv_q <= adv; // RULE3
      end
   end

   assign MEM_REQ = mreq_q;
   assign PIPE_ADVANCE = adv_q;
   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
endmodule : swps_top

/* swps_cfg.svh */
// Function
// RULE1 - Keep per-instruction mode flag: set when fetched from central memory.
// RULE2 - Next-location flag selects next-instruction register, else buffer data register.
// RULE3 - Raise termination when instruction completes; it advances the pipe.
// RULE4 - Raise read-command on memory read start, write-command on write start.
// RULE5 - Raise write-cycle-equality when effective address matches next instruction address.
// RULE6 - Keep skip-taken flag and shift-update flag per instruction.
// RULE7 - Keep flag marking instruction indirect through communications or general register.
// RULE8 - Keep flag: branch-and-load-counter followed by counter-relative branch.
// RULE9 - Copy served processor's instruction register into main register each execution time.
// RULE10 - All per-processor registers used are those of the active processor.
// RULE11 - Steps held with lowest bit inverted; state classes held in transformed form.
// RULE12 - Store word starts class 4 step 1; waits buffer available, routes word.
// RULE13 - Communications register by 6-bit field, general register by 3-bit select.
// RULE14 - Step 1 moves buffer data to next-instruction register, sets next-location, sends address.
// RULE15 - Step 1 stores effective address plus one for the equality test.
// RULE16 - Step 1 ends with memory write request and move to class 3 step 1.
// RULE17 - Step 2 with equality copies stored word to next-instruction register, class 3 step 2.
// RULE18 - Step 2 without equality advances pipe, loading instruction register from next instruction.
// RULE19 - Pipe advance sends program counter as address, then increments it.
// RULE20 - Pipe advance clears next-location flag and issues memory read request.
// RULE21 - Step 3 advances pipe using freshly stored word.
// RULE22 - Each step waits for the active processor's buffer-available indication.
// RULE23 - Memory side completes requests, returns read data, reasserts availability.
`ifndef SWPS_CFG_SVH
`define SWPS_CFG_SVH
`define SWPS_NVP 8
`define SWPS_VPW 3
`define SWPS_EAW 16
`define SWPS_AW 10
`define SWPS_NGR 8
`define SWPS_NCR 64
`define SWPS_OP_STORE_WORD 8'h40
// Instruction word fields
`define SWPS_W_OP 31:24
`define SWPS_W_SRC 23:18
`define SWPS_W_CR 17
`define SWPS_W_IND 16
`define SWPS_W_EA 15:0
// Stored state class codes (defined 3, 4, 7)
`define SWPS_CLS3_ST 3'h0
`define SWPS_CLS4_ST 3'h7
`define SWPS_CLS7_ST 3'h4
// Defined state class values
`define SWPS_CLS2_DEF 3'h2
`define SWPS_CLS3_DEF 3'h3
`define SWPS_CLS4_DEF 3'h4
`define SWPS_CLS7_DEF 3'h7
// Step definitions; stored form inverts the low bit
`define SWPS_STEP1_DEF 3'h0
`define SWPS_STEP2_DEF 3'h1
`define SWPS_STEP8_DEF 3'h7
`define SWPS_STEP_INV 3'h1
// Register byte addresses
`define SWPS_A_CTRL 10'h000
`define SWPS_A_STATUS 10'h004
`define SWPS_A_VPSEL 10'h008
`define SWPS_A_PC 10'h00c
`define SWPS_A_IRW 10'h010
`define SWPS_A_FLAGS 10'h014
`define SWPS_A_NIR 10'h018
`define SWPS_A_BDR 10'h01c
`define SWPS_GR_BASE 5'h01
`define SWPS_CR_BASE 2'h1
`define SWPS_F_CLS 14:12
`define SWPS_F_STP 18:16
`define SWPS_F_FLG 9:0
`define SWPS_F_RUN 0
`define SWPS_GR_RGN 9:5
`define SWPS_GR_IDX 4:2
`define SWPS_CR_RGN 9:8
`define SWPS_CR_IDX 7:2
`endif

/* swps_pkg.sv */
`include "swps_cfg.svh"
package swps_pkg;
   typedef struct packed {
      logic rbf;
      logic rind;
      logic shupd;
      logic skip;
      logic write_cycle_equality;
      logic wc;
      logic rc;
      logic term;
      logic next_location_flag;
      logic mode;
   } swps_flag_s;
   typedef struct packed {
      logic [7:0] op;
      logic [5:0] src;
      logic is_cr;
      logic [2:0] cls;
      logic [2:0] stp;
      logic [`SWPS_EAW-1:0] ea;
      logic [`SWPS_EAW-1:0] eap1;
      swps_flag_s flg;
   } swps_ir_s;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [`SWPS_VPW-1:0] vp;
      logic [`SWPS_EAW-1:0] addr;
      logic [31:0] wdata;
   } swps_mreq_s;
   typedef enum logic {PH_LOAD, PH_EXEC} swps_phase_e;
endpackage : swps_pkg

/* swps_monitor.sv */
`timescale 1ns/1ps
module swps_monitor (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Register bus
   input wire logic [9:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   // Memory side
   input wire logic [7:0] MEM_AVAIL,
   input swps_pkg::swps_mreq_s MEM_REQ,
   input wire logic PIPE_ADVANCE
);
   import swps_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   // ****************************************
   // Bus and memory request checks
   // ****************************************
   sequence s_req;
      MEM_REQ.rd || MEM_REQ.wr;
   endsequence
   sequence s_bus_wait;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   a_wait_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
      else $error("waitrequest dropped with no request");
   a_wait_bound: assert property (s_bus_wait |-> ##[1:2] !AVS_WAITREQUEST)
      else $error("bus access not answered in time");
   a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS >= 10'h200 |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   a_one_kind: assert property (!(MEM_REQ.rd && MEM_REQ.wr))
      else $error("read and write request together");
   a_req_pulse: assert property (s_req |=> !(MEM_REQ.rd || MEM_REQ.wr))
      else $error("memory request longer than one cycle");
   a_adv_read: assert property (PIPE_ADVANCE == MEM_REQ.rd)
      else $error("pipe advance without instruction fetch");
   a_avail_gate: assert property (s_req |-> (($past(MEM_AVAIL) >> MEM_REQ.vp) & 8'h01) != 8'h00)
      else $error("request issued while buffer busy");
endmodule : swps_monitor
bind swps_top swps_monitor mon_u (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .MEM_AVAIL(MEM_AVAIL), .MEM_REQ(MEM_REQ), .PIPE_ADVANCE(PIPE_ADVANCE));

/* swps_mem_model.sv */
`timescale 1ns/1ps
module swps_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Requests and answer delay
   input swps_pkg::swps_mreq_s req,
   input wire logic [7:0] lat,
   // Answers
   output logic [7:0] avail,
   output logic rvalid,
   output logic [2:0] rvp,
   output logic [31:0] rdata
);
   import swps_pkg::*;
   logic [31:0] mem [bit [15:0]];
   int cnt [8];
   logic prd [8];
   logic [15:0] radr [8];
   logic [31:0] last;
   logic busy;
   initial
   begin
      avail = 8'hff;
      rvalid = 1'b0;
      rvp = 3'h0;
      last = 32'h0;
      rdata = 32'hffff_ffff;
   end
   // One return per cycle; others wait, as a shared return bus would
   always @(posedge clk)
   begin
      rvalid <= 1'b0;
      rdata <= ~last;
      busy = 1'b0;
      if (rst)
      begin
         avail <= 8'hff;
         foreach (cnt[i]) cnt[i] = 0;
      end
      else
      begin
         for (int v = 0; v < 8; v++)
            if (cnt[v] > 1)
               cnt[v]--;
            else if (cnt[v] == 1 && !busy)
            begin
               cnt[v] = 0;
               avail[v] <= 1'b1;
               if (prd[v])
               begin
                  busy = 1'b1;
                  rvalid <= 1'b1;
                  rvp <= v[2:0];
                  last = mem.exists(radr[v]) ? mem[radr[v]] : {radr[v], ~radr[v]};
                  rdata <= last;
               end
            end
         if (req.rd || req.wr)
         begin
            avail[req.vp] <= 1'b0;
            cnt[req.vp] = (lat == 8'h0) ? 1 : int'(lat);
            prd[req.vp] = req.rd;
            radr[req.vp] = req.addr;
            if (req.wr)
               mem[req.addr] = req.wdata;
         end
      end
   end
endmodule : swps_mem_model

/* tb_swps.sv */
`timescale 1ns/1ps
`include "swps_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
   import swps_pkg::*;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic [9:0] adr = 10'h0;
   logic bus_rd = 1'b0;
   logic bus_wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic [7:0] avail;
   logic rvalid;
   logic [2:0] rvp;
   logic [31:0] rdata;
   swps_mreq_s mreq;
   logic adv;
   logic [7:0] lat = 8'h3c;
   int n_errors = 0;
   int checks_done = 0;
   always #20 CLK = ~CLK;
   swps_top dut_u (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(adr), .AVS_READ(bus_rd), .AVS_WRITE(bus_wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
      .MEM_AVAIL(avail), .MEM_RVALID(rvalid), .MEM_RVP(rvp), .MEM_RDATA(rdata), .MEM_REQ(mreq),
      .PIPE_ADVANCE(adv));
   swps_mem_model mem_u (.clk(CLK), .rst(RESET), .req(mreq), .lat(lat), .avail(avail), .rvalid(rvalid),
      .rvp(rvp), .rdata(rdata));
   // ****************************************
   // Bus and request helpers
   // ****************************************
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      bus_wr <= w;
      bus_rd <= !w;
      @(posedge CLK);
      while (wreq !== 1'b0 && n < 50)
      begin
         @(posedge CLK);
         n++;
      end
      `CHK("bus answer", 1'b0, wreq)
      q = rdat;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      @(posedge CLK);
   endtask : bus
   task automatic wr32(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr32
   task automatic rd32(input logic [9:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd32
   task automatic wait_req(input logic w, input logic [2:0] vp, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      while (!(mreq.rd || mreq.wr) && n < 400)
      begin
         @(posedge CLK);
         n++;
      end
      `CHK("req seen", 1'b1, mreq.rd | mreq.wr)
      `CHK("req kind", w, mreq.wr)
      `CHK("req vp", vp, mreq.vp)
      `CHK("req addr", a, mreq.addr)
      `CHK("advance", !w, adv)
      if (w) `CHK("req data", d, mreq.wdata)
   endtask : wait_req
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [31:0] q;
      rd32(`SWPS_A_FLAGS, q);
      `CHK("flags reset", 32'h0, q)
      rd32(`SWPS_A_STATUS, q);
      `CHK("run reset", 32'h0, q & 32'h8)
      wr32(10'h200, 32'hffff_ffff);
      rd32(10'h200, q);
      `CHK("unmapped", 32'h0, q)
   endtask : t_reset
   task automatic t_park();
      for (int v = 0; v < 8; v++)
      begin
         wr32(`SWPS_A_VPSEL, v);
         wr32(`SWPS_A_PC, v);
         wr32(`SWPS_A_IRW, 32'h0100_0000);
      end
   endtask : t_park
   task automatic t_store(input logic [2:0] vp, input logic cr, input logic [5:0] src, input logic [15:0] ea,
      input logic [15:0] pc, input logic [7:0] l);
      logic [31:0] q;
      logic eq;
      logic [31:0] word;
      logic [31:0] old;
      eq = (ea + 16'h1 == pc);
      word = {(eq ? 8'h40 : 8'h11), 8'h5a, pc};
      old = {(eq ? 8'h11 : 8'h40), 8'h00, 16'h0077};
      lat <= l;
      wr32(`SWPS_A_VPSEL, {29'h0, vp});
      wr32(`SWPS_A_PC, {16'h0, pc});
      wr32(`SWPS_A_BDR, old);
      wr32(cr ? {`SWPS_CR_BASE, src, 2'h0} : {`SWPS_GR_BASE, src[2:0], 2'h0}, word);
      wr32(`SWPS_A_IRW, {8'h40, src, cr, 1'b0, ea});
      rd32(`SWPS_A_FLAGS, q);
      `CHK("flags load", 32'h0001_7001, q & 32'h0007_703f)
      wr32(`SWPS_A_CTRL, 32'h1);
      wait_req(1'b1, vp, ea, word);
      rd32(`SWPS_A_FLAGS, q);
      `CHK("flags step1", 32'h0001_0013 | {26'h0, eq, 5'h0}, q & 32'h0007_703f)
      rd32(`SWPS_A_NIR, q);
      `CHK("nir saved", old, q)
      wait_req(1'b0, vp, pc, 32'h0);
      wr32(`SWPS_A_CTRL, 32'h0);
      rd32(`SWPS_A_PC, q);
      `CHK("pc step", {16'h0, pc + 16'h1}, q)
      rd32(`SWPS_A_FLAGS, q);
      `CHK("flags adv", 32'h0001_700d, q & 32'h0007_701f)
      `CHK("mem word", word, mem_u.mem[ea])
      // Park the processor so its new instruction stays out of later scenarios
      wr32(`SWPS_A_IRW, 32'h0100_0000);
   endtask : t_store
   task automatic t_isolate();
      logic [31:0] q;
      wr32(`SWPS_A_VPSEL, 32'h3);
      rd32(`SWPS_A_PC, q);
      `CHK("pc other vp", 32'h3, q)
      wr32(`SWPS_A_VPSEL, 32'h5);
      rd32(`SWPS_A_BDR, q);
      `CHK("fetched word", 32'h0201_fdfe, q)
   endtask : t_isolate
   task automatic summarize();
      $display("TB: errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (4) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      t_reset();
      t_park();
      // Slow memory, general register source, no equality
      t_store(3'h2, 1'b0, 6'h05, 16'h0400, 16'h0123, 8'h3c);
      // Prompt memory, communications register source, equality
      t_store(3'h5, 1'b1, 6'h2a, 16'h0200, 16'h0201, 8'h03);
      t_isolate();
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge CLK);
      n_errors++;
      summarize();
   end
endmodule : testbench
